// ==== isq_map.vh ====
`ifndef ISQ_MAP_VH
`define ISQ_MAP_VH
// register byte offsets
`define ISQ_OFS_CTRL      8'h00
`define ISQ_OFS_STATUS    8'h04
`define ISQ_OFS_NUM_SETS  8'h08
`define ISQ_OFS_LOOPS     8'h0C
`define ISQ_OFS_FPT       8'h10
`define ISQ_OFS_SET_SEL   8'h14
`define ISQ_OFS_EXPOSURE  8'h18
`define ISQ_OFS_GAIN      8'h1C
`define ISQ_OFS_ROI       8'h20
`define ISQ_OFS_IO        8'h24
`define ISQ_OFS_REPEAT    8'h28
// control field positions
`define ISQ_CTRL_ENABLE   0
`define ISQ_CTRL_FREE_RUN 1
`define ISQ_CTRL_ONCE     2
`define ISQ_CTRL_START    3
// status field positions
`define ISQ_ST_RUNNING    0
`define ISQ_ST_TRIG_WAIT  1
`define ISQ_ST_SET_LSB    8
// io register field positions
`define ISQ_IO_VAL_LSB    8
// widths
`define ISQ_SET_W         7
`define ISQ_CNT_W         17
`define ISQ_OUT_W         3
// reset values
`define ISQ_CTRL_RST      4'h4
`define ISQ_CNT_RST       17'h00001
`define ISQ_NSETS_RST     7'h00
`endif

// ==== isq_sync.v ====
`timescale 1ns/1ns
module isq_sync
(
  input  wire pclk,     // system clock
  input  wire presetn,  // async reset, active low
  input  wire ce,       // clock enable
  input  wire din,      // asynchronous pin level
  output reg  rise      // one-cycle pulse on synchronised rising edge
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // first stage feeds only the second stage
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      rise     <= 1'b0;
    end
    else if (ce)
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      rise     <= sync_reg & ~prev_reg;
    end
  end
endmodule

// ==== isq_set_mem.v ====
`timescale 1ns/1ns
`include "isq_map.vh"
module isq_set_mem
(
  input  wire                  pclk,     // system clock
  input  wire                  ce,       // clock enable
  input  wire [6:0]            waddr,    // set written by software
  input  wire [4:0]            wfield,   // one-hot field write strobes
  input  wire [31:0]           wdata,    // write data
  input  wire [6:0]            raddr_a,  // software readback set
  input  wire [6:0]            raddr_b,  // sequencer active set
  output wire [31:0]           exp_a,    // exposure, port a
  output wire [15:0]           gain_a,   // gain, port a
  output wire [31:0]           roi_a,    // y and x origin, port a
  output wire [5:0]            io_a,     // values and select, port a
  output wire [16:0]           rep_a,    // repeat count, port a
  output wire [31:0]           exp_b,    // exposure, port b
  output wire [15:0]           gain_b,   // gain, port b
  output wire [31:0]           roi_b,    // y and x origin, port b
  output wire [5:0]            io_b,     // values and select, port b
  output wire [16:0]           rep_b     // repeat count, port b
);
  // no reset on the arrays; software must program each used set
  reg [31:0] exp_mem  [0:127];
  reg [15:0] gain_mem [0:127];
  reg [31:0] roi_mem  [0:127];
  reg [5:0]  io_mem   [0:127];
  reg [16:0] rep_mem  [0:127];

  always @(posedge pclk)
  begin
    if (ce)
    begin
      if (wfield[0])
        exp_mem[waddr] <= wdata;
      if (wfield[1])
        gain_mem[waddr] <= wdata[15:0];
      if (wfield[2])
        roi_mem[waddr] <= wdata;
      if (wfield[3])
        io_mem[waddr] <= {wdata[`ISQ_IO_VAL_LSB+2:`ISQ_IO_VAL_LSB], wdata[2:0]};
      if (wfield[4])
        rep_mem[waddr] <= wdata[16:0];
    end
  end

  assign exp_a  = exp_mem[raddr_a];
  assign gain_a = gain_mem[raddr_a];
  assign roi_a  = roi_mem[raddr_a];
  assign io_a   = io_mem[raddr_a];
  assign rep_a  = rep_mem[raddr_a];
  assign exp_b  = exp_mem[raddr_b];
  assign gain_b = gain_mem[raddr_b];
  assign roi_b  = roi_mem[raddr_b];
  assign io_b   = io_mem[raddr_b];
  assign rep_b  = rep_mem[raddr_b];
endmodule

// ==== isq_top.v ====
// Function
// - A sequence is one ordered pass through all sets from the first to the last.
// - Each set captures as many frames as its repeat count before the next set.
// - The whole sequence repeats as many times as the loop count says.
// - After the last loop the sequencer stops and the final set stays applied.
// - A selection decides between immediate free-running start and waiting for a trigger.
// - A separate frames-per-trigger count sets how many frames each trigger captures.
// - Up to 128 sets are supported, programmed as count minus one.
// - Loop, repeat and frames-per-trigger counts each accept values up to 131071.
// - Each set holds exposure, gain, output values, repeat count and ROI origin.
// - A readable status tells whether the sequencer is running.
// - Each set holds output line selection and values, driven while the set is active.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`include "isq_map.vh"
module isq_top
(
  input  wire        pclk,         // system clock, 100 MHz
  input  wire        presetn,      // async reset, active low
  input  wire        ce,           // clock enable, freezes all state when low
  input  wire        psel,         // apb select
  input  wire        penable,      // apb enable
  input  wire        pwrite,       // apb direction
  input  wire [7:0]  paddr,        // apb byte address
  input  wire [31:0] pwdata,       // apb write data
  output reg  [31:0] prdata,       // apb read data
  output reg         pready,       // apb ready
  output reg         pslverr,      // apb error, unmapped address
  input  wire        ext_trigger,  // external trigger pin
  input  wire        frame_done,   // exposure logic finished a frame
  output reg         frame_start,  // one-cycle request for one frame
  output reg  [31:0] cur_exposure, // active set exposure
  output reg  [15:0] cur_gain,     // active set gain
  output reg  [15:0] cur_roi_x,    // active set roi x origin
  output reg  [15:0] cur_roi_y,    // active set roi y origin
  output reg  [2:0]  seq_out,      // sequencer output lines
  output reg  [2:0]  seq_out_oe    // output line selected by active set
);
  localparam ST_IDLE = 2'd0;
  localparam ST_TRIG = 2'd1;
  localparam ST_ISSUE = 2'd2;
  localparam ST_WAIT = 2'd3;

  //////////////////////////////////////////////////////////////////////////////
  // counter helper: a programmed zero acts as one
  function is_last;
    input [16:0] cnt;
    input [16:0] lim;
    begin
      is_last = ({1'b0, cnt} + 18'h00001) >= {1'b0, lim};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  reg  [3:0]  ctrl_reg;
  reg  [6:0]  nsets_reg;
  reg  [16:0] loops_reg;
  reg  [16:0] fpt_reg;
  reg  [6:0]  sel_reg;
  reg  [1:0]  state_reg;
  reg  [6:0]  set_reg;
  reg  [16:0] rep_cnt_reg;
  reg  [16:0] loop_cnt_reg;
  reg  [16:0] fpt_cnt_reg;
  reg         start_prev_reg;
  reg  [31:0] rdata_next;
  reg         err_next;
  reg  [4:0]  wfield;
  wire        trig_rise;
  wire        setup_ph;
  wire        wr_en;
  wire        run_req;
  wire        seq_done;
  wire [31:0] exp_a;
  wire [15:0] gain_a;
  wire [31:0] roi_a;
  wire [5:0]  io_a;
  wire [16:0] rep_a;
  wire [31:0] exp_b;
  wire [15:0] gain_b;
  wire [31:0] roi_b;
  wire [5:0]  io_b;
  wire [16:0] rep_b;

  isq_sync u_trig
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (ext_trigger),
    .rise    (trig_rise)
  );

  isq_set_mem u_mem
  (
    .pclk    (pclk),
    .ce      (ce),
    .waddr   (sel_reg),
    .wfield  (wfield),
    .wdata   (pwdata),
    .raddr_a (sel_reg),
    .raddr_b (set_reg),
    .exp_a   (exp_a),
    .gain_a  (gain_a),
    .roi_a   (roi_a),
    .io_a    (io_a),
    .rep_a   (rep_a),
    .exp_b   (exp_b),
    .gain_b  (gain_b),
    .roi_b   (roi_b),
    .io_b    (io_b),
    .rep_b   (rep_b)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb: answer prepared in setup, ready on the first access cycle
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pready & pwrite & ~pslverr;

  always @*
  begin
    rdata_next = 32'h00000000;
    err_next   = 1'b0;
    case (paddr)
      `ISQ_OFS_CTRL:     rdata_next = {28'h0000000, ctrl_reg};
      `ISQ_OFS_STATUS:
      begin
        rdata_next[`ISQ_ST_RUNNING] = state_reg != ST_IDLE;
        rdata_next[`ISQ_ST_TRIG_WAIT] = state_reg == ST_TRIG;
        rdata_next[`ISQ_ST_SET_LSB+6:`ISQ_ST_SET_LSB] = set_reg;
      end
      `ISQ_OFS_NUM_SETS: rdata_next = {25'h0000000, nsets_reg};
      `ISQ_OFS_LOOPS:    rdata_next = {15'h0000, loops_reg};
      `ISQ_OFS_FPT:      rdata_next = {15'h0000, fpt_reg};
      `ISQ_OFS_SET_SEL:  rdata_next = {25'h0000000, sel_reg};
      `ISQ_OFS_EXPOSURE: rdata_next = exp_a;
      `ISQ_OFS_GAIN:     rdata_next = {16'h0000, gain_a};
      `ISQ_OFS_ROI:      rdata_next = roi_a;
      `ISQ_OFS_IO:       rdata_next = {21'h000000, io_a[5:3], 5'h00, io_a[2:0]};
      `ISQ_OFS_REPEAT:   rdata_next = {15'h0000, rep_a};
      default:           err_next = 1'b1;
    endcase
  end

  // per-set field strobes into the set store
  always @*
  begin
    wfield = 5'h00;
    if (wr_en)
    begin
      case (paddr)
        `ISQ_OFS_EXPOSURE: wfield = 5'h01;
        `ISQ_OFS_GAIN:     wfield = 5'h02;
        `ISQ_OFS_ROI:      wfield = 5'h04;
        `ISQ_OFS_IO:       wfield = 5'h08;
        `ISQ_OFS_REPEAT:   wfield = 5'h10;
        default:           wfield = 5'h00;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph & err_next;
      if (setup_ph & ~pwrite)
        prdata <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // static configuration
  assign seq_done = (state_reg == ST_WAIT) & frame_done & ctrl_reg[`ISQ_CTRL_ONCE] &
                    is_last(rep_cnt_reg, rep_b) & (set_reg == nsets_reg) &
                    is_last(loop_cnt_reg, loops_reg);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg  <= `ISQ_CTRL_RST;
      nsets_reg <= `ISQ_NSETS_RST;
      loops_reg <= `ISQ_CNT_RST;
      fpt_reg   <= `ISQ_CNT_RST;
      sel_reg   <= 7'h00;
    end
    else if (ce)
    begin
      // a software write of the start bit wins over completion
      if (wr_en && paddr == `ISQ_OFS_CTRL)
        ctrl_reg <= pwdata[3:0];
      else if (seq_done)
        ctrl_reg[`ISQ_CTRL_START] <= 1'b0;
      if (wr_en && paddr == `ISQ_OFS_NUM_SETS)
        nsets_reg <= pwdata[6:0];
      if (wr_en && paddr == `ISQ_OFS_LOOPS)
        loops_reg <= pwdata[16:0];
      if (wr_en && paddr == `ISQ_OFS_FPT)
        fpt_reg <= pwdata[16:0];
      if (wr_en && paddr == `ISQ_OFS_SET_SEL)
        sel_reg <= pwdata[6:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  assign run_req = ctrl_reg[`ISQ_CTRL_ENABLE] & ctrl_reg[`ISQ_CTRL_START];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg      <= ST_IDLE;
      set_reg        <= 7'h00;
      rep_cnt_reg    <= 17'h00000;
      loop_cnt_reg   <= 17'h00000;
      fpt_cnt_reg    <= 17'h00000;
      start_prev_reg <= 1'b0;
      frame_start    <= 1'b0;
      cur_exposure   <= 32'h00000000;
      cur_gain       <= 16'h0000;
      cur_roi_x      <= 16'h0000;
      cur_roi_y      <= 16'h0000;
      seq_out        <= 3'h0;
      seq_out_oe     <= 3'h0;
    end
    else if (ce)
    begin
      start_prev_reg <= run_req;
      frame_start    <= 1'b0;
      if (!run_req)
        state_reg <= ST_IDLE;  // stop keeps the last applied set
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (!start_prev_reg)
            begin
              set_reg      <= 7'h00;
              rep_cnt_reg  <= 17'h00000;
              loop_cnt_reg <= 17'h00000;
              fpt_cnt_reg  <= 17'h00000;
              if (ctrl_reg[`ISQ_CTRL_FREE_RUN])
                state_reg <= ST_ISSUE;
              else
                state_reg <= ST_TRIG;
            end
          end
          ST_TRIG:
          begin
            // triggers only count here, never during a burst
            if (trig_rise)
            begin
              fpt_cnt_reg <= 17'h00000;
              state_reg   <= ST_ISSUE;
            end
          end
          ST_ISSUE:
          begin
            // apply the active set with the frame request
            cur_exposure <= exp_b;
            cur_gain     <= gain_b;
            cur_roi_x    <= roi_b[15:0];
            cur_roi_y    <= roi_b[31:16];
            seq_out      <= io_b[5:3] & io_b[2:0];
            seq_out_oe   <= io_b[2:0];
            frame_start  <= 1'b1;
            state_reg    <= ST_WAIT;
          end
          ST_WAIT:
          begin
            if (frame_done)
            begin
              if (!is_last(rep_cnt_reg, rep_b))
                rep_cnt_reg <= rep_cnt_reg + 17'h00001;
              else
              begin
                rep_cnt_reg <= 17'h00000;
                if (set_reg != nsets_reg)
                  set_reg <= set_reg + 7'h01;
                else
                begin
                  set_reg <= 7'h00;
                  if (!is_last(loop_cnt_reg, loops_reg))
                    loop_cnt_reg <= loop_cnt_reg + 17'h00001;
                  else
                    loop_cnt_reg <= 17'h00000;
                end
              end
              if (seq_done)
              begin
                set_reg   <= set_reg;
                state_reg <= ST_IDLE;
              end
              else if (ctrl_reg[`ISQ_CTRL_FREE_RUN])
                state_reg <= ST_ISSUE;
              else if (!is_last(fpt_cnt_reg, fpt_reg))
              begin
                fpt_cnt_reg <= fpt_cnt_reg + 17'h00001;
                state_reg   <= ST_ISSUE;
              end
              else
                state_reg <= ST_TRIG;
            end
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== isq_props.sv ====
`timescale 1ns/1ns
module isq_props
(
  input wire logic        pclk,         // system clock
  input wire logic        presetn,      // reset, active low
  input wire logic        ce,           // clock enable
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb enable
  input wire logic        pwrite,       // apb direction
  input wire logic [7:0]  paddr,        // apb address
  input wire logic [31:0] prdata,       // apb read data
  input wire logic        pready,       // apb ready
  input wire logic        pslverr,      // apb error
  input wire logic        frame_done,   // frame finished
  input wire logic        frame_start,  // frame request
  input wire logic [31:0] cur_exposure, // active exposure
  input wire logic [15:0] cur_gain,     // active gain
  input wire logic [2:0]  seq_out,      // output lines
  input wire logic [2:0]  seq_out_oe    // output selection
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_decode: assert property (pready |-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0))
    else $error("error flag does not match address map");
  a_prdata_read: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  a_start_pulse: assert property (frame_start |=> !frame_start)
    else $error("frame request longer than one cycle");
  a_done_gap: assert property (frame_done |=> !frame_start)
    else $error("frame request too soon after frame end");
  a_one_per_done: assert property (frame_start |=> !frame_start until frame_done)
    else $error("second frame request before frame end");
  a_params_hold: assert property (!frame_start |-> $stable({cur_exposure, cur_gain, seq_out, seq_out_oe}))
    else $error("set parameters moved without a frame request");
  a_out_masked: assert property ((seq_out & ~seq_out_oe) == 3'h0)
    else $error("unselected output line driven");
endmodule

// ==== isq_cam_model.sv ====
`timescale 1ns/1ns
module isq_cam_model
#(
  parameter int READOUT = 3 // sensor readout cycles
)
(
  input  wire logic        pclk,         // system clock
  input  wire logic        presetn,      // reset, active low
  input  wire logic        frame_start,  // frame request
  input  wire logic [31:0] cur_exposure, // active exposure
  input  wire logic [15:0] cur_gain,     // active gain
  input  wire logic [15:0] cur_roi_x,    // active roi x
  input  wire logic [15:0] cur_roi_y,    // active roi y
  input  wire logic [2:0]  seq_out,      // output lines
  input  wire logic [2:0]  seq_out_oe,   // output selection
  output logic             frame_done    // frame finished pulse
);
  logic [95:0] log_q[$];
  int          busy;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_done <= 1'b0;
      busy       <= 0;
    end
    else
    begin
      frame_done <= (busy == 1);
      if (frame_start)
      begin
        log_q.push_back({cur_exposure, cur_gain, cur_roi_y, cur_roi_x, 10'h000, seq_out_oe, seq_out});
        // low exposure bits pick prompt or slow frames; a short exposure still pays readout
        busy <= int'(cur_exposure[3:0]) + READOUT;
      end
      else if (busy > 0)
        busy <= busy - 1;
    end
  end
endmodule

// ==== image_parameter_sequencer_tb_top.sv ====
`timescale 1ns/1ns
`include "isq_map.vh"
module image_parameter_sequencer_tb_top;
  localparam int LIMIT = 20000;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} isq_row_t;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        ext_trigger, frame_done, frame_start, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, cur_exposure, q;
  logic [15:0] cur_gain, cur_roi_x, cur_roi_y;
  logic [2:0]  seq_out, seq_out_oe;
  logic [95:0] exp_q[$];
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;
  isq_row_t    rows [0:12] = '{
    '{1'b0, `ISQ_OFS_CTRL, 32'h0, 32'h4, 1'b0}, '{1'b0, `ISQ_OFS_LOOPS, 32'h0, 32'h1, 1'b0},
    '{1'b0, `ISQ_OFS_FPT, 32'h0, 32'h1, 1'b0}, '{1'b0, `ISQ_OFS_NUM_SETS, 32'h0, 32'h0, 1'b0},
    '{1'b0, `ISQ_OFS_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b1, `ISQ_OFS_NUM_SETS, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b0, `ISQ_OFS_NUM_SETS, 32'h0, 32'h7F, 1'b0},
    '{1'b1, `ISQ_OFS_LOOPS, 32'h10000, 32'h0, 1'b0},
    '{1'b0, `ISQ_OFS_LOOPS, 32'h0, 32'h10000, 1'b0},
    '{1'b1, `ISQ_OFS_FPT, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, `ISQ_OFS_FPT, 32'h0, 32'h1FFFF, 1'b0},
    '{1'b0, 8'h2C, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h30, 32'h5, 32'h0, 1'b1}};
  logic [31:0] s_exp  [0:2] = '{32'h00000102, 32'h0000030F, 32'h00000208};
  logic [15:0] s_gain [0:2] = '{16'h0010, 16'h0020, 16'h0030};
  logic [31:0] s_roi  [0:2] = '{32'h00040008, 32'h000C0010, 32'h00140018};
  logic [10:0] s_io   [0:2] = '{11'h705, 11'h203, 11'h104};
  logic [16:0] s_rep  [0:2] = '{17'h3, 17'h1, 17'h2};

  isq_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trigger(ext_trigger), .frame_done(frame_done),
    .frame_start(frame_start), .cur_exposure(cur_exposure), .cur_gain(cur_gain),
    .cur_roi_x(cur_roi_x), .cur_roi_y(cur_roi_y), .seq_out(seq_out), .seq_out_oe(seq_out_oe));
  isq_cam_model u_cam (.pclk(pclk), .presetn(presetn), .frame_start(frame_start),
    .cur_exposure(cur_exposure), .cur_gain(cur_gain), .cur_roi_x(cur_roi_x),
    .cur_roi_y(cur_roi_y), .seq_out(seq_out), .seq_out_oe(seq_out_oe), .frame_done(frame_done));

  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [95:0] seen, input logic [95:0] want);
    n_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // request held until pready is seen, then released
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do
    begin
      apb(1'b0, `ISQ_OFS_STATUS, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 400);
  endtask
  task automatic fire;
    ext_trigger <= 1'b1;
    repeat (6) @(posedge pclk);
    ext_trigger <= 1'b0;
  endtask
  function automatic logic [95:0] ent(int s);
    ent = {s_exp[s], s_gain[s], s_roi[s], 10'h000, s_io[s][2:0], s_io[s][10:8] & s_io[s][2:0]};
  endfunction
  task automatic cmp_log;
    check(96'(u_cam.log_q.size()), 96'(exp_q.size()));
    foreach (exp_q[i])
      check(u_cam.log_q[i], exp_q[i]);
  endtask
  task automatic push_pair;
    exp_q.push_back(ent(0));
    exp_q.push_back(ent(1));
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      mismatches++;
      wrap_up;
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, ext_trigger} = 5'h00;
    ce     = 1'b1;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      check(96'(e), 96'(rows[i].e));
      if (!rows[i].wr)
        check(96'(q), 96'(rows[i].q));
    end
    for (int s = 0; s < 3; s++)
    begin
      wr(`ISQ_OFS_SET_SEL, 32'(s));
      wr(`ISQ_OFS_EXPOSURE, s_exp[s]);
      wr(`ISQ_OFS_GAIN, 32'(s_gain[s]));
      wr(`ISQ_OFS_ROI, s_roi[s]);
      wr(`ISQ_OFS_IO, 32'(s_io[s]));
      wr(`ISQ_OFS_REPEAT, 32'(s_rep[s]));
    end
    wr(`ISQ_OFS_NUM_SETS, 32'h2);
    wr(`ISQ_OFS_LOOPS, 32'h2);
    wr(`ISQ_OFS_CTRL, 32'hF);
    apb(1'b0, `ISQ_OFS_STATUS, 32'h0);
    check(96'(q[0]), 96'(1'b1));
    wait_idle;
    for (int l = 0; l < 2; l++)
      for (int s = 0; s < 3; s++)
        repeat (s_rep[s]) exp_q.push_back(ent(s));
    cmp_log;
    check(96'({cur_exposure, cur_gain}), 96'({s_exp[2], s_gain[2]}));
    apb(1'b0, `ISQ_OFS_CTRL, 32'h0);
    check(96'(q), 96'(32'h7));
    // double shutter: two sets, one loop, one repeat, two frames a trigger
    wr(`ISQ_OFS_NUM_SETS, 32'h1);
    wr(`ISQ_OFS_LOOPS, 32'h1);
    wr(`ISQ_OFS_SET_SEL, 32'h0);
    wr(`ISQ_OFS_REPEAT, 32'h1);
    wr(`ISQ_OFS_FPT, 32'h2);
    wr(`ISQ_OFS_CTRL, 32'hD);
    repeat (30) @(posedge pclk);
    check(96'(u_cam.log_q.size()), 96'(exp_q.size()));
    // parked for a trigger: running, waiting, set 0
    apb(1'b0, `ISQ_OFS_STATUS, 32'h0);
    check(96'(q), 96'(32'h3));
    fire;
    push_pair;
    wait_idle;
    cmp_log;
    wr(`ISQ_OFS_CTRL, 32'h9);
    fire;
    repeat (8) @(posedge pclk);
    fire;
    repeat (80) @(posedge pclk);
    push_pair;
    cmp_log;
    fire;
    repeat (80) @(posedge pclk);
    push_pair;
    cmp_log;
    wr(`ISQ_OFS_CTRL, 32'h0);
    apb(1'b0, `ISQ_OFS_STATUS, 32'h0);
    check(96'(q[0]), 96'(1'b0));
    // reset in mid-run: free-running cycle mode cut by a short reset pulse
    wr(`ISQ_OFS_CTRL, 32'hB);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check(96'({frame_start, cur_exposure, cur_gain, seq_out, seq_out_oe}), 96'(0));
    apb(1'b0, `ISQ_OFS_STATUS, 32'h0);
    check(96'(q), 96'(32'h0));
    apb(1'b0, `ISQ_OFS_CTRL, 32'h0);
    check(96'(q), 96'(`ISQ_CTRL_RST));
    wrap_up;
  end
endmodule

bind isq_top isq_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .frame_done(frame_done), .frame_start(frame_start),
  .cur_exposure(cur_exposure), .cur_gain(cur_gain), .seq_out(seq_out), .seq_out_oe(seq_out_oe));
